// [shared/pxp_pkg.sv]
// Notes on behaviour
// - Writing 0x0002 to register 31 selects extended page 2.
// - With page 2 selected, addresses 16..30 reach the page-2 registers.
// - Addresses 0..15 always reach the standard registers.
// - Writing 0x0000 to register 31 returns 16..30 to standard space.
// - Page-2 registers are visible only while register 31 holds 0x0002.
// - Offset 16 holds four writable 4-bit amplitude trim codes.
// - Gigabit trim code sits in bits 15:12, resets to 0000.
// - 100 Mb/s trim code sits in bits 11:8, resets to 0010.
// - 10 Mb/s trim code sits in bits 7:4, resets to 1011.
// - Low-power 10 Mb/s trim code sits in bits 3:0, resets to 1110.
// - Bit 15 enables low-power 10 Mb/s mode; resets to 0.
// - Bits 13:10 invert LED groups; zero means active-low drive.
// - Bit 5 with register 0 bits 6,13 = 10 allows forced gigabit link.
// - Bit 4 sends LPI on the line instead of MAC idles.
// - Bit 3 blocks transmit LPI on the line in 100 Mb/s mode unless bit 4 is set.
// - Bit 2 blocks forwarding received LPI to MAC in 100 Mb/s mode.
// - Bit 1 blocks transmit LPI on the line in gigabit mode unless bit 4 is set.
// - Bit 0 blocks forwarding received LPI to MAC in gigabit mode.
// - Page selection and page-2 registers are kept per port.
package pxp_pkg;
  // Number of ports served by this bank
  localparam int PXP_PORTS = 4;
  // Avalon word index map: bits 4:0 management register, bits 6:5 port
  localparam int PXP_REG_BITS = 5;
  localparam int PXP_PORT_BITS = 2;
  localparam int PXP_ADDR_BITS = 7;
  localparam logic [4:0] PXP_REG0_ADDR = 5'h00;
  localparam logic [4:0] PXP_LAST_STD_ADDR = 5'h0F;
  localparam logic [4:0] PXP_TRIM_ADDR = 5'h10;
  localparam logic [4:0] PXP_EEE_ADDR = 5'h11;
  localparam logic [4:0] PXP_PAGE_ADDR = 5'h1F;
  // Page select values
  localparam logic [15:0] PXP_PAGE_STD = 16'h0000;
  localparam logic [15:0] PXP_PAGE_EXT2 = 16'h0002;
  // Reset values
  localparam logic [3:0] PXP_TRIM_GIG_RST = 4'h0;
  localparam logic [3:0] PXP_TRIM_100_RST = 4'h2;
  localparam logic [3:0] PXP_TRIM_10_RST = 4'hB;
  localparam logic [3:0] PXP_TRIM_10E_RST = 4'hE;
  localparam logic [15:0] PXP_EEE_RST = 16'h0000;
  localparam logic [15:0] PXP_STD_RST = 16'h0000;
  // Writable bits of the energy-efficient register
  localparam logic [15:0] PXP_EEE_MASK = 16'hBC3F;
  // Register 0 bit positions for forced speed
  localparam int PXP_R0_SPD_LSB = 6;
  localparam int PXP_R0_SPD_MSB = 13;
  // Read wait cycles before acceptance; data is valid at acceptance
  localparam int PXP_RD_WAIT = 1;

  // Trim codes as seen by the line driver
  typedef struct packed {
    logic [3:0] gig;
    logic [3:0] fast;
    logic [3:0] ten;
    logic [3:0] ten_lp;
  } pxp_trim_s;

  // Energy-efficient controls as seen by the datapath
  typedef struct packed {
    logic ten_lp_en;
    logic [3:0] led_invert;
    logic force_gig_ok;
    logic force_lpi;
    logic inh_fast_tx;
    logic inh_fast_rx;
    logic inh_gig_tx;
    logic inh_gig_rx;
  } pxp_eee_s;

  // Line mode of one port, driven by the datapath
  typedef struct packed {
    logic mode_fast;
    logic mode_gig;
    logic mac_lpi;
    logic line_lpi;
  } pxp_lpi_in_s;

  // Gated LPI decisions towards line and MAC
  typedef struct packed {
    logic tx_lpi;
    logic rx_lpi;
  } pxp_lpi_out_s;
endpackage : pxp_pkg

// [src/pxp_lpi_gate.sv]
module pxp_lpi_gate (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Controls and status
  input wire pxp_pkg::pxp_eee_s ctl,
  input wire pxp_pkg::pxp_lpi_in_s stat,
  // Decisions
  output pxp_pkg::pxp_lpi_out_s dec
);
  import pxp_pkg::*;

  logic tx_next;
  logic rx_next;

  // Inhibit bits only apply to their own line rate
  always_comb begin
    tx_next = stat.mac_lpi;
    if (stat.mode_fast && ctl.inh_fast_tx) begin
      tx_next = 1'b0;
    end
    if (stat.mode_gig && ctl.inh_gig_tx) begin
      tx_next = 1'b0;
    end
    if (ctl.force_lpi) begin
      tx_next = 1'b1;
    end
    rx_next = stat.line_lpi;
    if (stat.mode_fast && ctl.inh_fast_rx) begin
      rx_next = 1'b0;
    end
    if (stat.mode_gig && ctl.inh_gig_rx) begin
      rx_next = 1'b0;
    end
  end

  // Registered so the top outputs come from flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dec <= '0;
    end else begin
      dec.tx_lpi <= tx_next;
      dec.rx_lpi <= rx_next;
    end
  end
endmodule : pxp_lpi_gate

// [src/pxp_led_drive.sv]
module pxp_led_drive (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Active-high indicator requests and inversion
  input wire logic [7:0] led_on,
  input wire logic [3:0] led_invert,
  // Pin levels
  output logic [7:0] indicator_outputs
);
  import pxp_pkg::*;

  // Each inversion bit covers the pair of pins of one group
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_grp
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          indicator_outputs[2*g+1:2*g] <= 2'h3; // Dark: active low
        end else begin
          indicator_outputs[2*g+1:2*g] <=
            led_invert[g] ? led_on[2*g+1:2*g] : ~led_on[2*g+1:2*g];
        end
      end
    end
  endgenerate
endmodule : pxp_led_drive

// [src/pxp_page2_regs.sv]
// Added by the designer: the Avalon-MM register port.
module pxp_page2_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [pxp_pkg::PXP_ADDR_BITS-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Per-port datapath status
  input wire pxp_pkg::pxp_lpi_in_s [pxp_pkg::PXP_PORTS-1:0] lpi_stat,
  input wire logic [pxp_pkg::PXP_PORTS-1:0][7:0] led_on,
  // Per-port controls
  output pxp_pkg::pxp_trim_s [pxp_pkg::PXP_PORTS-1:0] trim_codes,
  output logic [pxp_pkg::PXP_PORTS-1:0] ten_lp_enable,
  output logic [pxp_pkg::PXP_PORTS-1:0] force_gig_link,
  output pxp_pkg::pxp_lpi_out_s [pxp_pkg::PXP_PORTS-1:0] lpi_dec,
  output logic [pxp_pkg::PXP_PORTS-1:0][7:0] indicator_outputs
);
  import pxp_pkg::*;

  // Storage, one set per port
  logic [15:0] page_reg [PXP_PORTS];
  logic [15:0] trim_reg [PXP_PORTS];
  logic [15:0] eee_reg [PXP_PORTS];
  logic [15:0] std_reg [PXP_PORTS][32];
  pxp_eee_s eee_ctl [PXP_PORTS];

  // Bus handshake state
  logic rd_busy_reg;
  logic [15:0] rd_data_next;
  logic [PXP_PORT_BITS-1:0] acc_port;
  logic [PXP_REG_BITS-1:0] acc_reg;
  logic [15:0] wmask;
  logic [15:0] wdata;
  logic wr_go;

  assign acc_port = avs_address[PXP_ADDR_BITS-1:PXP_REG_BITS];
  assign acc_reg = avs_address[PXP_REG_BITS-1:0];
  assign wdata = avs_writedata[15:0];
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // Writes complete in the cycle they are seen
  assign wr_go = avs_write && !avs_read;

  // Page 2 is live only for exactly the page-2 value
  function automatic logic page2_hit(input logic [15:0] page,
                                     input logic [4:0] addr);
    page2_hit = (page == PXP_PAGE_EXT2) &&
                (addr > PXP_LAST_STD_ADDR) && (addr != PXP_PAGE_ADDR);
  endfunction : page2_hit

  // Byte-lane merge of a write into a stored word
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic [15:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // Reads answer after one wait cycle; writes never wait
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_busy_reg <= 1'b0;
    end else begin
      rd_busy_reg <= avs_read && !rd_busy_reg;
    end
  end

  always_comb begin
    avs_waitrequest = avs_read && !rd_busy_reg;
  end

  // Read mux: page register, page 2, else standard space
  always_comb begin
    rd_data_next = 16'h0000;
    if (acc_reg == PXP_PAGE_ADDR) begin
      rd_data_next = page_reg[acc_port];
    end else if (page2_hit(page_reg[acc_port], acc_reg)) begin
      if (acc_reg == PXP_TRIM_ADDR) begin
        rd_data_next = trim_reg[acc_port];
      end else if (acc_reg == PXP_EEE_ADDR) begin
        rd_data_next = eee_reg[acc_port];
      end else begin
        rd_data_next = 16'h0000;
      end
    end else begin
      rd_data_next = std_reg[acc_port][acc_reg];
    end
  end

  // Read data captured in the wait cycle of each read; upper half reads zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !rd_busy_reg) begin
      avs_readdata <= {16'h0000, rd_data_next};
    end
  end

  genvar p;
  generate
    for (p = 0; p < PXP_PORTS; p++) begin : g_port
      logic sel;
      assign sel = wr_go && (acc_port == PXP_PORT_BITS'(p));

      // Page select held per port, any value stored
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          page_reg[p] <= PXP_PAGE_STD;
        end else if (sel && acc_reg == PXP_PAGE_ADDR) begin
          page_reg[p] <= merge(page_reg[p], wdata, wmask);
        end
      end

      // Transmit amplitude trim; software should keep defaults unless needed
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          trim_reg[p] <= {PXP_TRIM_GIG_RST, PXP_TRIM_100_RST,
                          PXP_TRIM_10_RST, PXP_TRIM_10E_RST};
        end else if (sel && acc_reg == PXP_TRIM_ADDR &&
                     page2_hit(page_reg[p], acc_reg)) begin
          trim_reg[p] <= merge(trim_reg[p], wdata, wmask);
        end
      end

      // Energy-efficient control; reserved bits stay zero
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          eee_reg[p] <= PXP_EEE_RST;
        end else if (sel && acc_reg == PXP_EEE_ADDR &&
                     page2_hit(page_reg[p], acc_reg)) begin
          eee_reg[p] <= merge(eee_reg[p], wdata,
                              wmask & PXP_EEE_MASK);
        end
      end

      // Simple standard space stand-in: plain storage per address
      for (genvar a = 0; a < 32; a++) begin : g_std
        always_ff @(posedge core_clk or negedge reset_n) begin
          if (!reset_n) begin
            std_reg[p][a] <= PXP_STD_RST;
          end else if (sel && acc_reg == PXP_REG_BITS'(a) &&
                       PXP_REG_BITS'(a) != PXP_PAGE_ADDR &&
                       !page2_hit(page_reg[p], acc_reg)) begin
            std_reg[p][a] <= merge(std_reg[p][a], wdata, wmask);
          end
        end
      end

      // Field unpack
      assign eee_ctl[p] = '{ten_lp_en: eee_reg[p][15],
                            led_invert: eee_reg[p][13:10],
                            force_gig_ok: eee_reg[p][5],
                            force_lpi: eee_reg[p][4],
                            inh_fast_tx: eee_reg[p][3],
                            inh_fast_rx: eee_reg[p][2],
                            inh_gig_tx: eee_reg[p][1],
                            inh_gig_rx: eee_reg[p][0]};

      // Registered control outputs
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          trim_codes[p] <= '{PXP_TRIM_GIG_RST, PXP_TRIM_100_RST,
                             PXP_TRIM_10_RST, PXP_TRIM_10E_RST};
          ten_lp_enable[p] <= 1'b0;
          force_gig_link[p] <= 1'b0;
        end else begin
          trim_codes[p] <= trim_reg[p];
          ten_lp_enable[p] <= eee_ctl[p].ten_lp_en;
          // Forced 1000 only with speed bits 6,13 = 1,0
          force_gig_link[p] <= eee_ctl[p].force_gig_ok &&
            std_reg[p][PXP_REG0_ADDR][PXP_R0_SPD_LSB] &&
            !std_reg[p][PXP_REG0_ADDR][PXP_R0_SPD_MSB];
        end
      end

      pxp_lpi_gate u_gate (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .ctl(eee_ctl[p]),
        .stat(lpi_stat[p]),
        .dec(lpi_dec[p])
      );

      pxp_led_drive u_led (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .led_on(led_on[p]),
        .led_invert(eee_ctl[p].led_invert),
        .indicator_outputs(indicator_outputs[p])
      );
    end
  endgenerate
endmodule : pxp_page2_regs

// [bench/pxp_page2_properties.sv]
module pxp_page2_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register bus
  input wire logic [pxp_pkg::PXP_ADDR_BITS-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Port side
  input wire pxp_pkg::pxp_lpi_in_s [pxp_pkg::PXP_PORTS-1:0] lpi_stat,
  input wire pxp_pkg::pxp_trim_s [pxp_pkg::PXP_PORTS-1:0] trim_codes,
  input wire logic [pxp_pkg::PXP_PORTS-1:0] ten_lp_enable,
  input wire pxp_pkg::pxp_lpi_out_s [pxp_pkg::PXP_PORTS-1:0] lpi_dec
);
  import pxp_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Shadow of each port's page select, so checks know the space hit
  logic [15:0] page_reg [PXP_PORTS];
  logic [4:0] reg_idx;
  logic on_p2;
  logic rd_acc;
  assign reg_idx = avs_address[4:0];
  assign on_p2 = page_reg[avs_address[6:5]] == PXP_PAGE_EXT2;
  assign rd_acc = avs_read && !avs_waitrequest;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < PXP_PORTS; i++) page_reg[i] <= PXP_PAGE_STD;
    end else if (avs_write && reg_idx == PXP_PAGE_ADDR) begin
      if (avs_byteenable[0])
        page_reg[avs_address[6:5]][7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1])
        page_reg[avs_address[6:5]][15:8] <= avs_writedata[15:8];
    end
  end
  // Read handshake: one wait cycle, then acceptance
  sequence rd_take_s;
    avs_waitrequest ##1 rd_acc;
  endsequence
  // Write of port 0 trim code while page 2 is open, any byte lanes
  sequence trim_wr_s;
    avs_write && on_p2 && avs_address == {2'h0, PXP_TRIM_ADDR};
  endsequence
  rd_wait_a: assert property ($rose(avs_read) |-> rd_take_s)
    else $error("read not answered after one wait cycle");
  wr_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  rd_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  rd_upper_a: assert property (rd_acc |=> avs_readdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  rsvd_zero_a: assert property (rd_acc && on_p2 && reg_idx > 5'h11 &&
    reg_idx < PXP_PAGE_ADDR |=> avs_readdata == 32'h0)
    else $error("reserved page-2 register not zero");
  eee_rsvd_a: assert property (rd_acc && on_p2 && reg_idx == PXP_EEE_ADDR
    |=> (avs_readdata[15:0] & ~PXP_EEE_MASK) == 16'h0)
    else $error("reserved control bits not zero");
  trim_out_a: assert property ((trim_wr_s and avs_byteenable[1:0] == 2'h3)
    |-> ##2 trim_codes[0] == $past(avs_writedata[15:0], 2))
    else $error("trim output does not follow write");
  trim_hide_a: assert property (trim_wr_s or (avs_write && !on_p2)
    |-> on_p2 or (##1 $stable(trim_codes[0]) ##1 $stable(trim_codes[0])))
    else $error("trim changed outside page 2");
  rx_gate_a: assert property (!lpi_stat[0].line_lpi |=> !lpi_dec[0].rx_lpi)
    else $error("receive LPI without line LPI");
endmodule : pxp_page2_properties

bind pxp_page2_regs pxp_page2_properties chk (.core_clk, .reset_n,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .lpi_stat, .trim_codes, .ten_lp_enable,
  .lpi_dec);

// [bench/pxp_page2_regs_bench.sv]
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
  num_errors++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end

module pxp_page2_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pxp_pkg::*;
  logic core_clk = 1'h0;
  logic reset_n;
  logic [3:0] avs_byteenable = 4'hF;
  logic [PXP_ADDR_BITS-1:0] avs_address = 7'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  pxp_lpi_in_s [PXP_PORTS-1:0] lpi_stat = 16'h0;
  logic [PXP_PORTS-1:0][7:0] led_on = 32'h0;
  pxp_trim_s [PXP_PORTS-1:0] trim_codes;
  logic [PXP_PORTS-1:0] ten_lp_enable;
  logic [PXP_PORTS-1:0] force_gig_link;
  pxp_lpi_out_s [PXP_PORTS-1:0] lpi_dec;
  logic [PXP_PORTS-1:0][7:0] indicator_outputs;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [15:0] rdata;
  // Control value, line status {fast,gig,mac,line}, expected {tx,rx}
  localparam logic [15:0] EEE_T [8] = '{16'h0, 16'h8, 16'h4, 16'h2,
    16'h1, 16'h2, 16'h10, 16'h0};
  localparam logic [3:0] ST_T [8] = '{4'hB, 4'hB, 4'hB, 4'h7, 4'h7,
    4'hB, 4'h4, 4'h4};
  localparam logic [1:0] EX_T [8] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h2,
    2'h3, 2'h2, 2'h0};

  pxp_page2_regs dut (.core_clk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .lpi_stat, .led_on, .trim_codes, .ten_lp_enable,
    .force_gig_link, .lpi_dec, .indicator_outputs);

  // Clock
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // Hang guard, far above the under two hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // Write request held until waitrequest is seen low at an edge
  task automatic bus_wr(input logic [1:0] p, input logic [4:0] r,
                        input logic [15:0] d);
    @(posedge core_clk);
    avs_address <= {p, r};
    avs_writedata <= {16'h0, d};
    avs_write <= 1'h1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
    avs_write <= 1'h0;
  endtask : bus_wr

  // Read data taken at the edge that sees waitrequest low
  task automatic rd_chk(input logic [1:0] p, input logic [4:0] r,
                        input logic [15:0] ex);
    @(posedge core_clk);
    avs_address <= {p, r};
    avs_read <= 1'h1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
    rdata = avs_readdata[15:0];
    avs_read <= 1'h0;
    `CHK("register read", ex, rdata)
  endtask : rd_chk

  initial begin
    // Driven at time zero so the asynchronous reset sees a falling edge
    reset_n <= 1'h0;
    repeat (5) @(posedge core_clk);
    `CHK("trim during reset", 16'h02BE, trim_codes[3])
    `CHK("pins during reset", 8'hFF, indicator_outputs[0])
    repeat (5) @(posedge core_clk);
    reset_n <= 1'h1;
    bus_wr(2'h0, 5'h1F, 16'h0002);
    rd_chk(2'h0, 5'h10, 16'h02BE);
    rd_chk(2'h0, 5'h11, 16'h0000);
    bus_wr(2'h0, 5'h1F, 16'h0000);
    $display("test reset values done");
    bus_wr(2'h1, 5'h10, 16'h1234);
    bus_wr(2'h1, 5'h05, 16'h0055);
    bus_wr(2'h1, 5'h1F, 16'h0002);
    rd_chk(2'h1, 5'h10, 16'h02BE);
    bus_wr(2'h1, 5'h10, 16'hA5C3);
    rd_chk(2'h1, 5'h10, 16'hA5C3);
    rd_chk(2'h1, 5'h05, 16'h0055);
    `CHK("trim port 1", 16'hA5C3, trim_codes[1])
    rd_chk(2'h0, 5'h10, 16'h0000);
    `CHK("trim port 0", 16'h02BE, trim_codes[0])
    bus_wr(2'h1, 5'h1F, 16'h0003);
    rd_chk(2'h1, 5'h10, 16'h1234);
    bus_wr(2'h1, 5'h1F, 16'h0000);
    rd_chk(2'h1, 5'h10, 16'h1234);
    bus_wr(2'h1, 5'h1F, 16'h0002);
    rd_chk(2'h1, 5'h10, 16'hA5C3);
    bus_wr(2'h1, 5'h12, 16'hFFFF);
    rd_chk(2'h1, 5'h12, 16'h0000);
    rd_chk(2'h1, 5'h1E, 16'h0000);
    bus_wr(2'h1, 5'h11, 16'hFFFF);
    rd_chk(2'h1, 5'h11, 16'hBC3F);
    `CHK("low-power enable", 1'h1, ten_lp_enable[1])
    bus_wr(2'h0, 5'h1F, 16'h0002);
    bus_wr(2'h0, 5'h10, 16'h7F18);
    // Low byte lane only
    avs_byteenable <= 4'h1;
    bus_wr(2'h0, 5'h10, 16'hFFC4);
    avs_byteenable <= 4'hF;
    rd_chk(2'h0, 5'h10, 16'h7FC4);
    bus_wr(2'h0, 5'h10, 16'h02BE);
    rd_chk(2'h0, 5'h10, 16'h02BE);
    `CHK("trim port 0 restored", 16'h02BE, trim_codes[0])
    bus_wr(2'h0, 5'h1F, 16'h0000);
    bus_wr(2'h0, 5'h10, 16'h5555);
    rd_chk(2'h0, 5'h10, 16'h5555);
    `CHK("trim port 0 hidden", 16'h02BE, trim_codes[0])
    $display("test paging done");
    bus_wr(2'h2, 5'h1F, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      bus_wr(2'h2, 5'h11, EEE_T[i]);
      lpi_stat[2] <= ST_T[i];
      repeat (3) @(posedge core_clk);
      `CHK("lpi decision", EX_T[i], lpi_dec[2])
    end
    $display("test lpi gating done");
    bus_wr(2'h3, 5'h1F, 16'h0002);
    led_on[3] <= 8'hA5;
    repeat (3) @(posedge core_clk);
    `CHK("indicator pins", 8'h5A, indicator_outputs[3])
    bus_wr(2'h3, 5'h11, 16'h0400);
    repeat (3) @(posedge core_clk);
    `CHK("inverted group", 8'h59, indicator_outputs[3])
    bus_wr(2'h3, 5'h00, 16'h0040);
    repeat (3) @(posedge core_clk);
    `CHK("force link off", 1'h0, force_gig_link[3])
    bus_wr(2'h3, 5'h11, 16'h0020);
    repeat (3) @(posedge core_clk);
    `CHK("speed code 10 forces", 1'h1, force_gig_link[3])
    bus_wr(2'h3, 5'h00, 16'h2000);
    repeat (3) @(posedge core_clk);
    `CHK("speed code 01 no force", 1'h0, force_gig_link[3])
    bus_wr(2'h3, 5'h00, 16'h2040);
    repeat (3) @(posedge core_clk);
    `CHK("both speed bits", 1'h0, force_gig_link[3])
    $display("test led and force done");
    finish_test();
  end
endmodule : pxp_page2_regs_bench
